// [rtl/router_pkg.sv]
// constants, layouts and types shared by the interrupt router
package router_pkg;

  localparam int          NUM_REQ_DEF   = 56;
  localparam int          PRIO_W        = 4;
  localparam int          IDX_W         = 6;
  localparam int          ADDR_W        = 12;

  // register byte addresses
  localparam logic [11:0] RAW_LO_OFS    = 12'h000;
  localparam logic [11:0] RAW_HI_OFS    = 12'h004;
  localparam logic [11:0] THR_FAST_OFS  = 12'h010;
  localparam logic [11:0] THR_NORM_OFS  = 12'h014;
  localparam logic [11:0] VEC_FAST_OFS  = 12'h020;
  localparam logic [11:0] VEC_NORM_OFS  = 12'h024;
  localparam logic [11:0] CFG_BASE_OFS  = 12'h100;
  localparam logic [11:0] CFG_LAST_OFS  = 12'h1DC;

  // field positions in a configuration word, one byte lane each, then in a vector word
  localparam int          CFG_PRIO_LSB  = 0;
  localparam int          CFG_TGT_BIT   = 8;
  localparam int          CFG_POL_BIT   = 16;
  localparam int          CFG_SW_BIT    = 24;
  localparam int          VEC_PRIO_LSB  = 8;
  localparam int          VEC_VALID_BIT = 31;

  localparam logic        TGT_FAST      = 1'h0;
  localparam logic        TGT_NORM      = 1'h1;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [3:0]  THR_RST       = 4'h0;

  typedef struct packed {
    logic              pol;
    logic              swreq;
    logic              tgt;
    logic [PRIO_W-1:0] prio;
  } cfg_t;

  typedef struct packed {
    logic              valid;
    logic [PRIO_W-1:0] prio;
    logic [IDX_W-1:0]  idx;
  } vec_t;

  localparam cfg_t        CFG_RST       = '{pol: 1'h0, swreq: 1'h0, tgt: 1'h0, prio: 4'h0};

endpackage : router_pkg

// [rtl/interrupt_router.sv]
// vectored interrupt router with AXI4-Lite register access
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module interrupt_router #(
  parameter int NUM_REQ = router_pkg::NUM_REQ_DEF
) (
  // router branch clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // request inputs
  input  wire logic [NUM_REQ-1:0]            req_in,
  // processor interrupt inputs
  output logic                               fast_interrupt_input,
  output logic                               normal_interrupt_input,
  // axi4-lite write
  input  wire logic [router_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  // axi4-lite read
  input  wire logic [router_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready
);
  import router_pkg::*;

  cfg_t                cfg [NUM_REQ];
  logic [PRIO_W-1:0]   thr_f;
  logic [PRIO_W-1:0]   thr_n;
  logic [NUM_REQ-1:0]  raw;
  vec_t                vec_f;
  vec_t                vec_n;
  logic [NUM_REQ-1:0]  pol_v;
  logic [NUM_REQ-1:0]  sw_v;
  logic [NUM_REQ-1:0]  qual_f;
  logic [NUM_REQ-1:0]  qual_n;
  vec_t                sel_f;
  vec_t                sel_n;
  logic                aw_full;
  logic                w_full;
  logic [ADDR_W-1:0]   wa;
  logic [31:0]         wd;
  logic [3:0]          ws;
  logic                do_write;
  logic [IDX_W:0]      wr_ci;
  logic [IDX_W:0]      rd_ci;
  logic [31:0]         rd_word;

  // hit flag above the configuration slot index
  function automatic logic [IDX_W:0] cfg_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - CFG_BASE_OFS;
    cfg_index = {(a >= CFG_BASE_OFS) && (a <= CFG_LAST_OFS) && (a[1:0] == 2'h0),
                 off[IDX_W+1:2]};
  endfunction : cfg_index

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    logic [IDX_W:0] ci;
    ci = cfg_index(a);
    mapped = ci[IDX_W] || (a == RAW_LO_OFS) || (a == RAW_HI_OFS) ||
             (a == THR_FAST_OFS) || (a == THR_NORM_OFS) ||
             (a == VEC_FAST_OFS) || (a == VEC_NORM_OFS);
  endfunction : mapped

  // strict compare keeps the first (lowest) index among equal levels
  function automatic vec_t pick(input logic [NUM_REQ-1:0] q, input cfg_t c [NUM_REQ]);
    vec_t r;
    r = '0;
    for (int i = 0; i < NUM_REQ; i++) begin
      if (q[i] && (c[i].prio > r.prio)) begin
        r.valid = 1'b1;
        r.prio  = c[i].prio;
        r.idx   = IDX_W'(i);
      end
    end
    pick = r;
  endfunction : pick

  function automatic logic [31:0] vec_word(input vec_t v);
    logic [31:0] w;
    w = '0;
    w[IDX_W-1:0] = v.idx;
    w[VEC_PRIO_LSB +: PRIO_W] = v.prio;
    w[VEC_VALID_BIT] = v.valid;
    vec_word = w;
  endfunction : vec_word

  // qualification per target and winner selection
  always_comb begin
    for (int i = 0; i < NUM_REQ; i++) begin
      pol_v[i]  = cfg[i].pol;
      sw_v[i]   = cfg[i].swreq;
      qual_f[i] = raw[i] && (cfg[i].tgt == TGT_FAST) &&
                  (cfg[i].prio != '0) && (cfg[i].prio > thr_f);
      qual_n[i] = raw[i] && (cfg[i].tgt == TGT_NORM) &&
                  (cfg[i].prio != '0) && (cfg[i].prio > thr_n);
    end
    sel_f = pick(qual_f, cfg);
    sel_n = pick(qual_n, cfg);
  end

  // raw state: polarity applied and software request merged, before masking
  always_ff @(posedge core_clk) begin
    if (rst) begin
      raw <= '0;
    end else begin
      raw <= (req_in ^ pol_v) | sw_v;
    end
  end

  // outputs registered; a gated branch clock simply freezes them
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vec_f                  <= '0;
      vec_n                  <= '0;
      fast_interrupt_input   <= 1'b0;
      normal_interrupt_input <= 1'b0;
    end else begin
      vec_f                  <= sel_f;
      vec_n                  <= sel_n;
      fast_interrupt_input   <= sel_f.valid;
      normal_interrupt_input <= sel_n.valid;
    end
  end

  // write channels: address and data taken independently, held until the response is taken
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign wr_ci    = cfg_index(wa);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      wa            <= '0;
      wd            <= '0;
      ws            <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full       <= 1'b1;
        wa            <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full       <= 1'b1;
        wd           <= s_axi_wdata;
        ws           <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // configuration slots; each field in its own byte lane so strobes can update one alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_REQ; i++) begin
        cfg[i] <= CFG_RST;
      end
    end else if (do_write && wr_ci[IDX_W]) begin
      if (ws[0]) begin
        cfg[wr_ci[IDX_W-1:0]].prio <= wd[CFG_PRIO_LSB +: PRIO_W];
      end
      if (ws[1]) begin
        cfg[wr_ci[IDX_W-1:0]].tgt <= wd[CFG_TGT_BIT];
      end
      if (ws[2]) begin
        cfg[wr_ci[IDX_W-1:0]].pol <= wd[CFG_POL_BIT];
      end
      if (ws[3]) begin
        cfg[wr_ci[IDX_W-1:0]].swreq <= wd[CFG_SW_BIT];
      end
    end
  end

  // thresholds; an isr raises its own target's threshold to nest
  always_ff @(posedge core_clk) begin
    if (rst) begin
      thr_f <= THR_RST;
      thr_n <= THR_RST;
    end else if (do_write && ws[0]) begin
      if (wa == THR_FAST_OFS) begin
        thr_f <= wd[PRIO_W-1:0];
      end
      if (wa == THR_NORM_OFS) begin
        thr_n <= wd[PRIO_W-1:0];
      end
    end
  end

  // read mux
  assign rd_ci = cfg_index(s_axi_araddr);

  always_comb begin
    rd_word = '0;
    if (rd_ci[IDX_W]) begin
      rd_word[CFG_PRIO_LSB +: PRIO_W] = cfg[rd_ci[IDX_W-1:0]].prio;
      rd_word[CFG_TGT_BIT]            = cfg[rd_ci[IDX_W-1:0]].tgt;
      rd_word[CFG_POL_BIT]            = cfg[rd_ci[IDX_W-1:0]].pol;
      rd_word[CFG_SW_BIT]             = cfg[rd_ci[IDX_W-1:0]].swreq;
    end else begin
      case (s_axi_araddr)
        RAW_LO_OFS:   rd_word = raw[31:0];
        RAW_HI_OFS:   rd_word[NUM_REQ-33:0] = raw[NUM_REQ-1:32];
        THR_FAST_OFS: rd_word[PRIO_W-1:0] = thr_f;
        THR_NORM_OFS: rd_word[PRIO_W-1:0] = thr_n;
        VEC_FAST_OFS: rd_word = vec_word(vec_f);
        VEC_NORM_OFS: rd_word = vec_word(vec_n);
        default:      rd_word = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // checks
  logic [31:0]         raw_lo;
  logic [NUM_REQ-1:0]  raw_next;
  logic                bad_order;

  assign raw_lo   = raw[31:0];
  assign raw_next = (req_in ^ pol_v) | sw_v;

  // independent scan: nothing qualifying may beat the chosen winner
  always_comb begin
    bad_order = 1'b0;
    for (int i = 0; i < NUM_REQ; i++) begin
      if (qual_f[i] && ((cfg[i].prio > sel_f.prio) ||
          ((cfg[i].prio == sel_f.prio) && (IDX_W'(i) < sel_f.idx)))) begin
        bad_order = 1'b1;
      end
      if (qual_n[i] && ((cfg[i].prio > sel_n.prio) ||
          ((cfg[i].prio == sel_n.prio) && (IDX_W'(i) < sel_n.idx)))) begin
        bad_order = 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_rd_raw_lo;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == RAW_LO_OFS);
  endsequence

  sequence s_fast_qual;
    (|qual_f) ##0 (sel_f.prio > thr_f);
  endsequence

  a_raw_polarity: assert property (!rst ##1 1'b1 |-> raw == $past(raw_next))
    else $error("raw state does not follow polarity-adjusted inputs");

  a_sw_raises: assert property (|sw_v |=> ((raw & $past(sw_v)) == $past(sw_v)))
    else $error("software request did not raise its input");

  a_raw_readback: assert property (s_rd_raw_lo |=> s_axi_rvalid &&
                                   (s_axi_rdata == $past(raw_lo)))
    else $error("raw state read back wrong");

  a_fast_routing: assert property ((|qual_f) |-> sel_f.valid &&
                                   (cfg[sel_f.idx].tgt == TGT_FAST))
    else $error("fast winner not routed to fast target");

  a_norm_routing: assert property ((|qual_n) |-> sel_n.valid &&
                                   (cfg[sel_n.idx].tgt == TGT_NORM))
    else $error("normal winner not routed to normal target");

  a_thresh_mask: assert property (fast_interrupt_input |-> $past(sel_f.prio) > $past(thr_f))
    else $error("fast output raised at or below threshold");

  a_zero_masked: assert property ((fast_interrupt_input || normal_interrupt_input) |->
                                  ((vec_f.prio != '0) || !fast_interrupt_input) &&
                                  ((vec_n.prio != '0) || !normal_interrupt_input))
    else $error("priority zero caused an interrupt");

  a_top_wins: assert property (!bad_order)
    else $error("winner is not highest priority lowest index");

  a_vector_tracks: assert property (s_fast_qual |=> vec_f.valid &&
                                    (vec_f.idx == $past(sel_f.idx)))
    else $error("fast vector does not name the winner");

  a_output_cause: assert property ((|qual_n) |=> normal_interrupt_input ##0
                                   (vec_n.prio > $past(thr_n)))
    else $error("normal output missing for qualifying request");

  a_output_quiet: assert property (!(|qual_f) && !(|qual_n) |=>
                                   !fast_interrupt_input && !normal_interrupt_input)
    else $error("output raised with no qualifying request");

  a_norm_mask: assert property (normal_interrupt_input |->
                                $past(sel_n.prio) > $past(thr_n))
    else $error("normal output raised at or below threshold");

  // both halves of a write are held until the response has been taken
  sequence s_write_fire;
    aw_full && w_full && !s_axi_bvalid;
  endsequence

  sequence s_resp_taken;
    s_axi_bvalid && s_axi_bready;
  endsequence

  a_write_answer: assert property (s_write_fire |=> s_axi_bvalid &&
                                   !s_axi_awready && !s_axi_wready)
    else $error("write response did not follow the write");

  a_ready_back: assert property (s_resp_taken |=> !s_axi_bvalid &&
                                 s_axi_awready && s_axi_wready)
    else $error("write channels not reopened after the response");

  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
                                  s_axi_rvalid && !s_axi_arready)
    else $error("read data did not follow the read address");

endmodule : interrupt_router

// [bench/core_irq_model.sv]
// processor-side model that counts entries into each interrupt service
`timescale 1ns/1ps
module core_irq_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // lines from the router
  input  wire logic       fast_interrupt_input,
  input  wire logic       normal_interrupt_input,
  // service entries seen
  output logic [7:0]      fast_entries,
  output logic [7:0]      norm_entries
);
  logic fast_q;
  logic norm_q;
  // a level held high is one entry; the core re-enters only after the line drops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fast_q       <= 1'h0;
      norm_q       <= 1'h0;
      fast_entries <= 8'h00;
      norm_entries <= 8'h00;
    end else begin
      fast_q <= fast_interrupt_input;
      norm_q <= normal_interrupt_input;
      if (fast_interrupt_input && !fast_q) begin
        fast_entries <= fast_entries + 8'h01;
      end
      if (normal_interrupt_input && !norm_q) begin
        norm_entries <= norm_entries + 8'h01;
      end
    end
  end
endmodule : core_irq_model

// [bench/vectored_interrupt_router_tb.sv]
// self-checking bench for the interrupt router
`timescale 1ns/1ps
module vectored_interrupt_router_tb;
  import router_pkg::*;
  typedef struct packed {
    logic [5:0] idx;
    logic [3:0] prio;
    logic       tgt;
    logic       pol;
    logic [3:0] thr;
    logic       lvl;
    logic       fire;
  } row_t;
  logic        core_clk = 1'h0;
  logic        rst = 1'h1;
  logic        clk_on = 1'h1;
  logic [55:0] req_in = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        fast_interrupt_input, normal_interrupt_input;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  fast_entries, norm_entries, n0;
  logic [63:0] exp_raw;
  row_t        rw;
  int          errors = 0, num_checks = 0, cycles = 0;
  // idx, prio, target, polarity, threshold, line level, should fire
  row_t        rows [6] = '{
    '{6'h05, 4'h3, 1'h1, 1'h0, 4'h0, 1'h1, 1'h1},
    '{6'h00, 4'h1, 1'h0, 1'h0, 4'h0, 1'h1, 1'h1},
    '{6'h37, 4'hF, 1'h0, 1'h1, 4'hE, 1'h0, 1'h1},
    '{6'h20, 4'h7, 1'h1, 1'h1, 4'h0, 1'h1, 1'h0},
    '{6'h28, 4'h4, 1'h1, 1'h0, 4'h4, 1'h1, 1'h0},
    '{6'h09, 4'h0, 1'h0, 1'h0, 4'h0, 1'h1, 1'h0}};

  interrupt_router dut (.core_clk, .rst, .req_in, .fast_interrupt_input,
    .normal_interrupt_input, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  core_irq_model core (.core_clk, .rst, .fast_interrupt_input, .normal_interrupt_input,
    .fast_entries, .norm_entries);

  // gating stops the branch clock in its low phase
  always #12.5 if (clk_on) core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd

  // two edges: raw capture, then the output flop
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle

  function automatic logic [31:0] cw(logic [3:0] p, logic t, logic pl, logic sw);
    return {7'h00, sw, 7'h00, pl, 7'h00, t, 4'h0, p};
  endfunction : cw

  function automatic logic [31:0] ve(logic [3:0] p, logic [5:0] i);
    return {1'h1, 19'h00000, p, 2'h0, i};
  endfunction : ve

  function automatic logic [11:0] ca(logic [5:0] i);
    return CFG_BASE_OFS + {4'h0, i, 2'h0};
  endfunction : ca

  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    rd(THR_FAST_OFS);
    chk(d, 32'h0);
    rd(CFG_LAST_OFS);
    chk(d, 32'h0);
    #1;
    chk(32'({fast_interrupt_input, normal_interrupt_input}), 32'h0);
    // unmapped and read-only places
    wr(12'h200, 32'h1);
    chk(32'(r), 32'(RESP_SLVERR));
    rd(12'h008);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(RAW_LO_OFS, 32'hFFFFFFFF);
    chk(32'(r), 32'(RESP_OKAY));
    foreach (rows[k]) begin
      rw = rows[k];
      wr(rw.tgt ? THR_NORM_OFS : THR_FAST_OFS, {28'h0, rw.thr});
      wr(ca(rw.idx), cw(rw.prio, rw.tgt, rw.pol, 1'h0));
      req_in[rw.idx] <= rw.lvl;
      settle();
      exp_raw = 64'(rw.lvl ^ rw.pol) << rw.idx;
      chk(32'(fast_interrupt_input), 32'(rw.fire & ~rw.tgt));
      chk(32'(normal_interrupt_input), 32'(rw.fire & rw.tgt));
      rd(RAW_LO_OFS);
      chk(d, exp_raw[31:0]);
      rd(RAW_HI_OFS);
      chk(d, exp_raw[63:32]);
      rd(rw.tgt ? VEC_NORM_OFS : VEC_FAST_OFS);
      if (rw.fire) chk(d, ve(rw.prio, rw.idx));
      else chk(32'(d[31]), 32'h0);
      req_in <= '0;
      wr(ca(rw.idx), 32'h0);
    end
    // software request with the line idle
    wr(ca(6'h0C), cw(4'h6, TGT_FAST, 1'h0, 1'h1));
    settle();
    chk(32'(fast_interrupt_input), 32'h1);
    rd(RAW_LO_OFS);
    chk(d, 32'h00001000);
    rd(VEC_FAST_OFS);
    chk(d, ve(4'h6, 6'h0C));
    chk(32'(fast_entries), 32'h3);
    wr(ca(6'h0C), 32'h0);
    // tie on the top level, then nesting by raising the threshold
    n0 = norm_entries;
    wr(THR_NORM_OFS, 32'h0);
    wr(ca(6'h03), cw(4'h5, TGT_NORM, 1'h0, 1'h0));
    wr(ca(6'h0A), cw(4'h9, TGT_NORM, 1'h0, 1'h0));
    wr(ca(6'h02), cw(4'h9, TGT_NORM, 1'h0, 1'h0));
    req_in <= 56'h00_0000_0000_040C;
    settle();
    rd(VEC_NORM_OFS);
    chk(d, ve(4'h9, 6'h02));
    wr(THR_NORM_OFS, 32'h9);
    settle();
    chk(32'(normal_interrupt_input), 32'h0);
    wr(ca(6'h32), cw(4'hC, TGT_NORM, 1'h0, 1'h0));
    req_in <= 56'h04_0000_0000_040C;
    settle();
    chk(32'(normal_interrupt_input), 32'h1);
    chk(32'(fast_interrupt_input), 32'h0);
    rd(VEC_NORM_OFS);
    chk(d, ve(4'hC, 6'h32));
    chk(32'(norm_entries), 32'(n0 + 8'h02));
    // a stopped branch clock freezes the output
    @(negedge core_clk);
    clk_on = 1'h0;
    req_in <= '0;
    #310;
    chk(32'(normal_interrupt_input), 32'h1);
    clk_on = 1'h1;
    settle();
    chk(32'(normal_interrupt_input), 32'h0);
    // second reset in mid-run clears the setup
    @(posedge core_clk);
    req_in <= 56'h04_0000_0000_040C;
    rst <= 1'h1;
    repeat (3) @(posedge core_clk);
    rst <= 1'h0;
    settle();
    chk(32'(normal_interrupt_input), 32'h0);
    rd(THR_NORM_OFS);
    chk(d, 32'h0);
    rd(ca(6'h32));
    chk(d, 32'h0);
    // byte strobes: only the priority lane of the word lands
    s_axi_wstrb <= 4'h1;
    wr(ca(6'h07), 32'h0101_0105);
    s_axi_wstrb <= 4'hF;
    rd(ca(6'h07));
    chk(d, 32'h00000005);
    tally_and_finish();
  end
endmodule : vectored_interrupt_router_tb
